// ==== common/dma_pkg.sv ====
// Shared constants and types of the two-channel transfer sequencer.
// Assumes a 32-bit register bus and a 32-bit system bus master port.
package dma_pkg;

    // ********************************************************************
    // Sizes
    // ********************************************************************
    localparam int NCH = 2;
    localparam int PREQ_N = 8;
    localparam int SEL_W = 3;
    localparam int CNT_W = 17;
    localparam int MODE_W = 7;
    localparam int STAT_STRIDE = 4;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [7:0] REG_PRIO = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_PEND = 8'h0c;
    localparam logic [4:0] CH_MODE = 5'h00;
    localparam logic [4:0] CH_SRC = 5'h04;
    localparam logic [4:0] CH_DST = 5'h08;
    localparam logic [4:0] CH_CNT = 5'h0c;
    localparam logic [4:0] CH_CLR = 5'h10;
    localparam logic [4:0] CH_SEL = 5'h14;

    // ********************************************************************
    // Field positions and reset values
    // ********************************************************************
    localparam int MB_ARQ = 0;
    localparam int MB_SZ = 1;
    localparam int MB_SDP = 3;
    localparam int MB_DDP = 4;
    localparam int MB_BRQ = 5;
    localparam int MB_IMK = 6;
    localparam logic [NCH-1:0] MASK_RST = 2'h3;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;

    typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_RD, ST_WR} seq_state_t;

    // Address step for one unit of the given size.
    function automatic logic [31:0] step_of(input logic [1:0] sz);
        return (sz == SZ_BYTE) ? 32'h1 : ((sz == SZ_HALF) ? 32'h2 : 32'h4);
    endfunction

endpackage

// ==== common/arb_if.sv ====
// Request and grant signals between the sequencer and its channel arbiter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface arb_if;
    logic [1:0] req;
    logic rr_mode;
    logic upd;
    logic upd_ch;
    logic gnt_valid;
    logic gnt_ch;
    modport requester(output req, rr_mode, upd, upd_ch, input gnt_valid, gnt_ch);
    modport arbiter(input req, rr_mode, upd, upd_ch, output gnt_valid, gnt_ch);
endinterface

// ==== logic/rst_sync.sv ====
// Reset release synchroniser: asynchronous assert, two-stage release.
// Assumes rst_n is active low and may be asynchronous to clk.
`timescale 1ns/1ps
module rst_sync (
    // Clock and raw reset.
    input wire logic clk,
    input wire logic rst_n,
    // Released reset.
    output logic rst_sync_n
);
    logic stage_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            stage_r <= 1'b1;
            rst_sync_n <= stage_r;
        end
    end
endmodule

// ==== logic/dma_arbiter.sv ====
// Two-channel priority arbiter, fixed or round-robin.
// Assumes upd pulses once when a channel finishes a unit or a whole burst.
`timescale 1ns/1ps
module dma_arbiter
    import dma_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Sequencer side.
    arb_if.arbiter port
);
    // Channel that currently ranks highest.
    logic top_r;
    logic first;

    // R23: round robin rank
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            top_r <= 1'b0;
        end else if (port.upd) begin
            top_r <= port.rr_mode ? ~port.upd_ch : 1'b0;
        end
    end

    assign first = port.rr_mode ? top_r : 1'b0;
    assign port.gnt_valid = |port.req;
    assign port.gnt_ch = port.req[first] ? first : ~first;
endmodule

// ==== logic/dma_transfer_sequencer.sv ====
// Two-channel DMA transfer sequencer with an Avalon-MM register slave.
// Assumes a system bus arbiter answering bus_req with bus_gnt, and a bus
// that answers each read or write with m_ack, plus m_err on a fault.
//
// Notes on behaviour
// R1: Cycle-steal drops request after each unit.
// R2: Cycle-steal re-requests while transfers remain.
// R3: Higher channel served after current steal unit.
// R4: Burst holds request until count exhausted.
// R5: No preemption during a burst.
// R6: Software uses cycle-steal for peripheral requests.
// R7: Count exhausted ends channel, sets completion.
// R8: Bus error stops channel, raises interrupt.
// R9: Error records channel and read/write phase.
// R10: Mask suspends after write, no interrupt.
// R11: Pending status: 0 ended, 1 suspended.
// R12: Request flag set regardless of interrupt mask.
// R13: Addresses hold next, or faulting, address.
// R14: Count decrements on good source read.
// R15: Auto request needs no peripheral signal.
// R16: External mode waits for selected peripheral.
// R17: All channels masked after reset.
// R18: Software configures mask, priority, mode, select.
// R19: Software masks, clears, programs, unmasks.
// R20: Software clears status before restarting.
// R21: Uncleared status blocks a new start.
// R22: Software never targets own registers.
// R23: Round robin lowers finished channel; ch0 first.
// R24: Clear-register write clears channel flags.
// R25: Incrementing device steps; fixed device holds.
// R26: Wait for grant before bus access.
// R27: Read into holding register, then write.
`timescale 1ns/1ps
module dma_transfer_sequencer
    import dma_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM register slave.
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // System bus ownership.
    output logic bus_req,
    input wire logic bus_gnt,
    // System bus master access.
    output logic [31:0] m_addr,
    output logic [1:0] m_size,
    output logic m_read,
    output logic m_write,
    output logic [31:0] m_wdata,
    input wire logic [31:0] m_rdata,
    input wire logic m_ack,
    input wire logic m_err,
    // Peripheral requests and completion indication.
    input wire logic [PREQ_N-1:0] periph_req,
    output logic [NCH-1:0] done_irq
);

    // ********************************************************************
    // Reset and arbiter
    // ********************************************************************
    logic rst_s_n;

    rst_sync u_rst (
        .clk(clk),
        .rst_n(rst_n),
        .rst_sync_n(rst_s_n)
    );

    arb_if arb ();

    dma_arbiter u_arb (
        .clk(clk),
        .rst_n(rst_s_n),
        .port(arb)
    );

    // ********************************************************************
    // Register bus slave
    // ********************************************************************
    // Every access waits exactly one cycle so read data comes from a flop.
    logic ack_r, wr_go, prio_rr_r;
    logic [31:0] rdata_r, rd_mux;
    logic [NCH-1:0] mask_r;
    logic [2:0] ch_idx;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_go = avs_write & ack_r;
    assign avs_readdata = rdata_r;
    assign ch_idx = avs_address[7:5];

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            prio_rr_r <= 1'b0;
        end else if (wr_go && avs_address == REG_PRIO) begin
            prio_rr_r <= avs_writedata[0];
        end
    end

    // R17: masked out of reset
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            mask_r <= MASK_RST;
        end else if (wr_go && avs_address == REG_MASK) begin
            mask_r <= avs_writedata[NCH-1:0];
        end
    end

    // ********************************************************************
    // Sequencer state
    // ********************************************************************
    seq_state_t state_r;
    logic cur_r;
    logic [NCH-1:0] cur_oh;
    logic [31:0] hold_r, maddr_r;
    logic [1:0] msize_r;
    logic rd_ack, wr_ack, cont;

    // Per-channel views used by the sequencer.
    logic [NCH-1:0][31:0] src_v, dst_v, chrd;
    logic [NCH-1:0][1:0] size_v;
    logic [NCH-1:0][2:0] flag_v;
    logic [NCH-1:0] burst_v, cnt_nz, elig, pend_v;

    // Per-channel events of the current access.
    logic [NCH-1:0] ev_rd_ok, ev_rd_err, ev_wr_ok, ev_wr_err, ev_end, ev_susp;

    assign cur_oh = 2'(1) << cur_r;
    assign rd_ack = (state_r == ST_RD) & m_ack;
    assign wr_ack = (state_r == ST_WR) & m_ack;
    assign ev_rd_ok = {NCH{rd_ack & ~m_err}} & cur_oh;
    assign ev_rd_err = {NCH{rd_ack & m_err}} & cur_oh;
    assign ev_wr_ok = {NCH{wr_ack & ~m_err}} & cur_oh;
    assign ev_wr_err = {NCH{wr_ack & m_err}} & cur_oh;
    // R7: count exhausted ends
    assign ev_end = ev_wr_ok & ~cnt_nz;
    // R10: suspend after write
    assign ev_susp = ev_wr_ok & cnt_nz & mask_r;

    // R4: burst keeps ownership
    // R5: no preemption in burst
    assign cont = burst_v[cur_r] & cnt_nz[cur_r] & ~mask_r[cur_r];

    // ********************************************************************
    // Channel registers
    // ********************************************************************
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic hit, pend_r;
            logic [4:0] fo;
            logic [MODE_W-1:0] mode_r;
            logic [SEL_W-1:0] sel_r;
            logic [31:0] src_r, dst_r;
            logic [CNT_W-1:0] cnt_r;
            // Flags, low bit first: request, error cause, error phase.
            logic [2:0] flag_r;
            logic [1:0] sz;

            assign hit = wr_go && ch_idx == 3'(g + 1);
            assign fo = avs_address[4:0];
            assign sz = mode_r[MB_SZ+1:MB_SZ];

            always_ff @(posedge clk or negedge rst_s_n) begin
                if (!rst_s_n) begin
                    mode_r <= '0;
                    sel_r <= '0;
                end else if (hit && fo == CH_MODE) begin
                    mode_r <= avs_writedata[MODE_W-1:0];
                end else if (hit && fo == CH_SEL) begin
                    sel_r <= avs_writedata[SEL_W-1:0];
                end
            end

            // R13: source holds next or faulting
            // R25: source step or hold
            always_ff @(posedge clk or negedge rst_s_n) begin
                if (!rst_s_n) begin
                    src_r <= '0;
                end else if (hit && fo == CH_SRC) begin
                    src_r <= avs_writedata;
                end else if (ev_rd_ok[g] && mode_r[MB_SDP]) begin
                    src_r <= src_r + step_of(sz);
                end
            end

            // R13: destination holds next or faulting
            // R25: destination step or hold
            always_ff @(posedge clk or negedge rst_s_n) begin
                if (!rst_s_n) begin
                    dst_r <= '0;
                end else if (hit && fo == CH_DST) begin
                    dst_r <= avs_writedata;
                end else if (ev_wr_ok[g] && mode_r[MB_DDP]) begin
                    dst_r <= dst_r + step_of(sz);
                end
            end

            // R14: decrement on good read
            always_ff @(posedge clk or negedge rst_s_n) begin
                if (!rst_s_n) begin
                    cnt_r <= '0;
                end else if (hit && fo == CH_CNT) begin
                    cnt_r <= avs_writedata[CNT_W-1:0];
                end else if (ev_rd_ok[g]) begin
                    cnt_r <= cnt_r - CNT_W'(1);
                end
            end

            // Hardware setting comes last so an event beats a clear in the same cycle.
            always_ff @(posedge clk or negedge rst_s_n) begin
                if (!rst_s_n) begin
                    flag_r <= 3'h0;
                end else begin
                    // R24: any write clears flags
                    if (hit && fo == CH_CLR) begin
                        flag_r <= 3'h0;
                    end
                    // R12: flag ignores interrupt mask
                    if (ev_end[g]) begin
                        flag_r <= 3'h1;
                    end
                    // R8: error raises interrupt
                    // R9: error phase recorded
                    if (ev_rd_err[g] || ev_wr_err[g]) begin
                        flag_r <= {ev_wr_err[g], 2'h3};
                    end
                end
            end

            // R11: pending data status
            always_ff @(posedge clk or negedge rst_s_n) begin
                if (!rst_s_n) begin
                    pend_r <= 1'b0;
                end else if (ev_end[g] || ev_rd_err[g] || ev_wr_err[g]) begin
                    pend_r <= 1'b0;
                end else if (ev_susp[g]) begin
                    pend_r <= 1'b1;
                end
            end

            // R15: auto request
            // R16: selected peripheral request
            // R21: uncleared status blocks
            assign elig[g] = ~mask_r[g] & ~flag_r[0] & (cnt_r != '0) & (mode_r[MB_ARQ] | periph_req[sel_r]);

            assign src_v[g] = src_r;
            assign dst_v[g] = dst_r;
            assign size_v[g] = sz;
            assign burst_v[g] = ~mode_r[MB_BRQ];
            assign cnt_nz[g] = cnt_r != '0;
            assign flag_v[g] = flag_r;
            assign pend_v[g] = pend_r;
            assign done_irq[g] = flag_r[0] & ~mode_r[MB_IMK];

            always_comb begin
                case (fo)
                    CH_MODE: chrd[g] = 32'(mode_r);
                    CH_SRC: chrd[g] = src_r;
                    CH_DST: chrd[g] = dst_r;
                    CH_CNT: chrd[g] = 32'(cnt_r);
                    CH_SEL: chrd[g] = 32'(sel_r);
                    default: chrd[g] = '0;
                endcase
            end
        end
    endgenerate

    // ********************************************************************
    // Register read data
    // ********************************************************************
    // Unmapped addresses and the write-only clear register read as zero.
    always_comb begin
        rd_mux = '0;
        case (avs_address)
            REG_PRIO: rd_mux = 32'(prio_rr_r);
            REG_MASK: rd_mux = 32'(mask_r);
            REG_STAT: begin
                for (int i = 0; i < NCH; i++) begin
                    rd_mux[i*STAT_STRIDE +: 3] = flag_v[i];
                end
            end
            REG_PEND: rd_mux = 32'(pend_v);
            default: begin
                if (ch_idx >= 3'd1 && ch_idx <= 3'(NCH)) begin
                    rd_mux = chrd[1'(ch_idx - 3'd1)];
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            rdata_r <= '0;
        end else if (avs_read && !ack_r) begin
            rdata_r <= rd_mux;
        end
    end

    // ********************************************************************
    // Arbiter hookup
    // ********************************************************************
    assign arb.req = elig;
    assign arb.rr_mode = prio_rr_r;
    assign arb.upd_ch = cur_r;
    // R23: rank moves at unit or burst end
    assign arb.upd = (wr_ack & (m_err | ~cont)) | (rd_ack & m_err);

    // ********************************************************************
    // Transfer sequencer
    // ********************************************************************
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                // R3: next winner picked between units
                ST_IDLE: begin
                    if (arb.gnt_valid) begin
                        state_r <= ST_REQ;
                    end
                end
                // R26: access only after grant
                ST_REQ: begin
                    if (bus_gnt) begin
                        state_r <= ST_RD;
                    end
                end
                // R8: read error stops at once
                ST_RD: begin
                    if (m_ack) begin
                        state_r <= m_err ? ST_IDLE : ST_WR;
                    end
                end
                // R1: steal unit drops request
                // R2: re-request from idle
                ST_WR: begin
                    if (m_ack) begin
                        state_r <= (!m_err && cont) ? ST_RD : ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            cur_r <= 1'b0;
            msize_r <= '0;
        end else if (state_r == ST_IDLE && arb.gnt_valid) begin
            cur_r <= arb.gnt_ch;
            msize_r <= size_v[arb.gnt_ch];
        end
    end

    // The source address is taken after the read step so a burst reads the next unit.
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            maddr_r <= '0;
        end else if (state_r == ST_REQ && bus_gnt) begin
            maddr_r <= src_v[cur_r];
        end else if (rd_ack && !m_err) begin
            maddr_r <= dst_v[cur_r];
        end else if (wr_ack && !m_err && cont) begin
            maddr_r <= src_v[cur_r];
        end
    end

    // R27: holding register
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            hold_r <= '0;
        end else if (rd_ack && !m_err) begin
            hold_r <= m_rdata;
        end
    end

    assign bus_req = state_r != ST_IDLE;
    assign m_read = state_r == ST_RD;
    assign m_write = state_r == ST_WR;
    assign m_addr = maddr_r;
    assign m_size = msize_r;
    assign m_wdata = hold_r;

endmodule

// ==== tb/dma_assertions.sv ====
// Concurrent checks on the sequencer's system bus master port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module dma_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // System bus.
    input wire logic bus_req,
    input wire logic bus_gnt,
    input wire logic [31:0] m_addr,
    input wire logic [1:0] m_size,
    input wire logic m_read,
    input wire logic m_write,
    input wire logic [31:0] m_wdata,
    input wire logic [31:0] m_rdata,
    input wire logic m_ack,
    input wire logic m_err,
    // Completion.
    input wire logic [1:0] done_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_reset_quiet;
        $rose(rst_n) |-> (!bus_req && done_irq == 2'h0) [*5];
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("bus request right after reset");
    property p_grant_first;
        $rose(m_read) |-> $past(bus_gnt);
    endproperty
    a_grant_first: assert property (p_grant_first) else $error("read without grant");
    property p_owner;
        !bus_req |-> !m_read && !m_write;
    endproperty
    a_owner: assert property (p_owner) else $error("access without request");
    property p_one_phase;
        !(m_read && m_write);
    endproperty
    a_one_phase: assert property (p_one_phase) else $error("read and write together");
    property p_write_follows;
        m_read && m_ack && !m_err |=> m_write && m_wdata == $past(m_rdata);
    endproperty
    a_write_follows: assert property (p_write_follows) else $error("held data not written");
    property p_hold;
        (m_read || m_write) && !m_ack |=> $stable(m_addr) && m_read == $past(m_read) && m_write == $past(m_write);
    endproperty
    a_hold: assert property (p_hold) else $error("access dropped early");
    property p_error_stop;
        m_ack && m_err && (m_read || m_write) |=> !m_read && !m_write;
    endproperty
    a_error_stop: assert property (p_error_stop) else $error("no stop on error");
    property p_size;
        (m_read || m_write) && $past(m_read || m_write) |-> $stable(m_size);
    endproperty
    a_size: assert property (p_size) else $error("size changed in unit");
endmodule
bind dma_transfer_sequencer dma_checker dma_checker_i (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
    .bus_gnt(bus_gnt), .m_addr(m_addr), .m_size(m_size), .m_read(m_read), .m_write(m_write),
    .m_wdata(m_wdata), .m_rdata(m_rdata), .m_ack(m_ack), .m_err(m_err), .done_irq(done_irq));

// ==== tb/bus_model.sv ====
// System bus arbiter and memory responder seen by the sequencer.
// Assumes one clock; dly sets grant and access wait in cycles.
`timescale 1ns/1ps
module bus_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Requests from the sequencer.
    input wire logic bus_req,
    input wire logic m_read,
    input wire logic m_write,
    input wire logic [31:0] m_addr,
    input wire logic [3:0] dly,
    // Answers.
    output logic bus_gnt,
    output logic m_ack,
    output logic m_err,
    output logic [31:0] m_rdata
);
    logic [3:0] g;
    logic [3:0] c;
    logic hit;
    assign hit = (m_read || m_write) && !m_ack && c >= dly;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            g <= 4'h0;
            c <= 4'h0;
            bus_gnt <= 1'b0;
            m_ack <= 1'b0;
            m_err <= 1'b0;
            m_rdata <= 32'h0;
        end else begin
            g <= (bus_req && !bus_gnt) ? g + 4'h1 : 4'h0;
            bus_gnt <= bus_req && (bus_gnt || g >= dly);
            c <= ((m_read || m_write) && !m_ack) ? c + 4'h1 : 4'h0;
            m_ack <= hit;
            // Addresses with bits 15:12 all ones stand for a reserved area that faults.
            m_err <= hit && m_addr[15:12] == 4'hf;
            // Idle read data toggles so a stale value never looks valid.
            m_rdata <= (hit && m_read) ? (m_addr ^ 32'h5a5a_0000) : ~m_rdata;
        end
    end
endmodule

// ==== tb/dma_transfer_sequencer_bench.sv ====
// Self-checking bench of the sequencer: register bus, bus model, requests.
// Assumes the bus model answers after dly cycles and faults at 0xfxxx.
`timescale 1ns/1ps
module dma_transfer_sequencer_bench import dma_pkg::*; ;
    typedef struct packed {logic [7:0] md; logic [15:0] sa, da; logic [7:0] n, st; logic [15:0] es, ed;
        logic [7:0] ec, rm; logic irq;} row_t;
    row_t rows [5] = '{'{8'h3d, 16'h100, 16'h200, 8'h3, 8'h1, 16'h10c, 16'h20c, 8'h0, 8'h1, 1'b1},
        '{8'h59, 16'h300, 16'h400, 8'h4, 8'h1, 16'h304, 16'h404, 8'h0, 8'h4, 1'b0},
        '{8'h33, 16'h500, 16'h600, 8'h2, 8'h1, 16'h500, 16'h604, 8'h0, 8'h1, 1'b1},
        '{8'h3d, 16'hf000, 16'h700, 8'h3, 8'h3, 16'hf000, 16'h700, 8'h3, 8'h0, 1'b1},
        '{8'h1d, 16'h800, 16'hf010, 8'h3, 8'h7, 16'h804, 16'hf010, 8'h2, 8'h0, 1'b1}};
    row_t r;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, bus_req, bus_gnt, m_read, m_write, m_ack, m_err;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, m_addr, m_wdata, m_rdata, q, c;
    logic [1:0] m_size, done_irq;
    logic [PREQ_N-1:0] periph_req = 8'h00;
    logic [3:0] dly = 4'h0;
    logic [7:0] seq;
    logic [7:0] pm [3] = '{8'h3d, 8'h3d, 8'h1d};
    logic [7:0] ps [3] = '{8'haf, 8'hbb, 8'haf};
    int n_mismatch = 0, tests_run = 0, nw = 0, run = 0, rmax = 0, i, k;
    always #50 clk = ~clk;
    dma_transfer_sequencer dma_transfer_sequencer_i (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .bus_req, .bus_gnt, .m_addr, .m_size, .m_read,
        .m_write, .m_wdata, .m_rdata, .m_ack, .m_err, .periph_req, .done_irq);
    bus_model bus_model_i (.clk, .rst_n, .bus_req, .m_read, .m_write, .m_addr, .dly, .bus_gnt, .m_ack,
        .m_err, .m_rdata);
    always @(posedge clk) begin
        if (m_write && m_ack && !m_err) begin
            nw <= nw + 1;
            seq <= {seq[5:0], m_addr[13:12]};
        end
        run <= !bus_req ? 0 : run + 32'(m_write && m_ack && !m_err);
        if (run > rmax) rmax <= run;
    end
    task automatic final_report();
        $display("compares=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // The request holds until the edge that samples waitrequest low; only the watchdog ends a hang.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    function automatic logic [7:0] ca(input int ch, input logic [4:0] o);
        return 8'((ch + 1) * 32) + {3'h0, o};
    endfunction
    task automatic setup(input int ch, input logic [31:0] m, s, d, n);
        wr(ca(ch, CH_CLR), 32'h0);
        wr(ca(ch, CH_MODE), m);
        wr(ca(ch, CH_SRC), s);
        wr(ca(ch, CH_DST), d);
        wr(ca(ch, CH_CNT), n);
    endtask
    task automatic poll(input logic [31:0] m);
        q = 32'h0;
        for (int t = 0; t < 60 && (q & m) !== m; t++) acc(1'b0, REG_STAT, 32'h0);
        chk(q & m, m);
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        final_report();
    end
    // ********************************************************************
    // Scenarios
    // ********************************************************************
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(REG_MASK, 32'h3);
        rchk(REG_STAT, 32'h0);
        rchk(8'hf0, 32'h0);
        for (i = 0; i < 5; i++) begin
            r = rows[i];
            setup(0, r.md, r.sa, r.da, r.n);
            rmax = 0;
            wr(REG_MASK, 32'h2);
            poll(32'h1);
            wr(REG_MASK, 32'h3);
            rchk(REG_STAT, r.st);
            rchk(REG_PEND, 32'h0);
            rchk(ca(0, CH_SRC), r.es);
            rchk(ca(0, CH_DST), r.ed);
            rchk(ca(0, CH_CNT), r.ec);
            chk(rmax, r.rm);
            chk(done_irq, r.irq);
            $display("row %0d done", i);
        end
        wr(ca(0, CH_DST), 32'h0a00);
        wr(ca(0, CH_CNT), 32'h2);
        wr(REG_MASK, 32'h2);
        repeat (20) @(posedge clk);
        rchk(ca(0, CH_CNT), 32'h2);
        wr(ca(0, CH_CLR), 32'h0);
        rchk(REG_STAT, 32'h0);
        poll(32'h1);
        wr(REG_MASK, 32'h3);
        $display("restart done");
        dly <= 4'h3;
        setup(0, 32'h3d, 32'h100, 32'h200, 32'h8);
        nw = 0;
        wr(REG_MASK, 32'h2);
        for (k = 0; k < 300 && nw < 2; k++) @(posedge clk);
        wr(REG_MASK, 32'h3);
        repeat (40) @(posedge clk);
        acc(1'b0, ca(0, CH_CNT), 32'h0);
        c = q;
        chk(nw, 32'h8 - c);
        rchk(REG_PEND, 32'h1);
        rchk(REG_STAT, 32'h0);
        rchk(ca(0, CH_DST), 32'h200 + (32'h8 - c) * 4);
        wr(REG_MASK, 32'h2);
        poll(32'h1);
        chk(nw, 32'h8);
        wr(REG_MASK, 32'h3);
        $display("suspend done");
        dly <= 4'h0;
        setup(1, 32'h3c, 32'h0b00, 32'h0c00, 32'h1);
        wr(ca(1, CH_SEL), 32'h5);
        wr(REG_MASK, 32'h1);
        repeat (20) @(posedge clk);
        rchk(ca(1, CH_CNT), 32'h1);
        periph_req <= 8'h20;
        poll(32'h10);
        periph_req <= 8'h00;
        wr(REG_MASK, 32'h3);
        $display("external done");
        for (i = 0; i < 3; i++) begin
            wr(REG_PRIO, 32'(i > 0));
            setup(0, pm[i], 32'h1000, 32'h2000, 32'h2);
            setup(1, pm[i], 32'h1100, 32'h3000, 32'h2);
            wr(REG_MASK, 32'h0);
            poll(32'h11);
            wr(REG_MASK, 32'h3);
            chk(seq, ps[i]);
            $display("priority %0d done", i);
        end
        final_report();
    end
endmodule
